/* File: rtl/gpp_pkg.sv */
// constants for the general purpose port pad control block
// assumes a 32-bit classic wishbone slave with byte addresses
package gpp_pkg;
  localparam int unsigned GPP_PINS = 8;
  localparam int unsigned GPP_BUS_PADS = 4;
  localparam int unsigned GPP_ADR_W = 8;
  localparam int unsigned GPP_DAT_W = 32;

  // register byte offsets
  localparam logic [7:0] GPP_OFF_PIN_LEVEL = 8'h00;
  localparam logic [7:0] GPP_OFF_LATCH = 8'h04;
  localparam logic [7:0] GPP_OFF_DIR = 8'h08;
  localparam logic [7:0] GPP_OFF_ANALOG = 8'h0c;
  localparam logic [7:0] GPP_OFF_DRAIN = 8'h10;
  localparam logic [7:0] GPP_OFF_SLEW = 8'h14;
  localparam logic [7:0] GPP_OFF_THRESH = 8'h18;
  localparam logic [7:0] GPP_OFF_PULLUP = 8'h1c;
  localparam logic [7:0] GPP_OFF_RISE_EN = 8'h20;
  localparam logic [7:0] GPP_OFF_FALL_EN = 8'h24;
  localparam logic [7:0] GPP_OFF_BUS_PAD = 8'h28;
  localparam logic [7:0] GPP_OFF_SINGLE = 8'h2c;

  // reset values
  localparam logic [7:0] GPP_RST_DIR = 8'hff;
  localparam logic [7:0] GPP_RST_ANALOG = 8'hff;
  localparam logic [7:0] GPP_RST_SLEW = 8'hff;
  localparam logic [7:0] GPP_RST_THRESH = 8'hff;
  localparam logic [7:0] GPP_RST_DRAIN = 8'h00;
  localparam logic [7:0] GPP_RST_PULLUP = 8'h00;
  localparam logic [7:0] GPP_RST_LATCH = 8'h00;
  localparam logic [7:0] GPP_RST_EDGE_EN = 8'h00;
  localparam logic [11:0] GPP_RST_BUS_PAD = 12'h000;

  // bus pad field positions, three bits per designated pad
  localparam int unsigned GPP_BP_FIELD_W = 3;
  localparam int unsigned GPP_BP_SLEW = 0;
  localparam int unsigned GPP_BP_PULLUP = 1;
  localparam int unsigned GPP_BP_THRESH = 2;

  // single input pin register fields
  localparam int unsigned GPP_SG_LEVEL = 0;
  localparam int unsigned GPP_SG_PULLUP = 1;
  localparam int unsigned GPP_SG_RISE = 2;
  localparam int unsigned GPP_SG_FALL = 3;
  localparam logic [3:0] GPP_RST_SINGLE = 4'h0;

  // port pin index of each designated bus pad
  localparam int unsigned GPP_BUS_PIN0 = 1;
  localparam int unsigned GPP_BUS_PIN1 = 2;
  localparam int unsigned GPP_BUS_PIN2 = 3;
  localparam int unsigned GPP_BUS_PIN3 = 4;
endpackage : gpp_pkg

/* File: rtl/gpp_port.sv */
// general purpose 8-bit port pad control with wishbone register access
// assumes pad cells outside resolve the wire from out and output enable
//
// Added by the designer: register access over Wishbone and the register offsets.
module gpp_port
  import gpp_pkg::*;
#(
  parameter int unsigned PINS = GPP_PINS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [GPP_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [GPP_DAT_W-1:0] wb_dat_i,
  output logic [GPP_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [PINS-1:0] pad_in_i,
  output logic [PINS-1:0] pad_out_o,
  output logic [PINS-1:0] pad_oe_o,
  output logic [PINS-1:0] pad_slew_limit_o,
  output logic [PINS-1:0] pad_ttl_sel_o,
  output logic [PINS-1:0] pad_pullup_o,
  output logic [PINS-1:0] pad_in_buf_en_o,
  output logic [PINS-1:0] periph_in_o,
  output logic [PINS-1:0] edge_change_irq_o,
  input wire logic [GPP_BUS_PADS-1:0] bus_st_in_i,
  output logic [GPP_BUS_PADS-1:0] bus_slew_o,
  output logic [GPP_BUS_PADS-1:0] bus_pullup_o,
  output logic [GPP_BUS_PADS-1:0] bus_thresh_o,
  input wire logic single_input_pin_i,
  input wire logic master_clear_enable_i,
  input wire logic low_volt_prog_enable_i,
  output logic single_pin_pullup_o,
  output logic single_edge_irq_o
);
  localparam int unsigned BUS_PIN [GPP_BUS_PADS] = '{GPP_BUS_PIN0, GPP_BUS_PIN1,
    GPP_BUS_PIN2, GPP_BUS_PIN3};

  logic [PINS-1:0] output_hold_latch_q;
  logic [PINS-1:0] direction_ctrl_q;
  logic [PINS-1:0] analog_select_q;
  logic [PINS-1:0] drain_select_q;
  logic [PINS-1:0] slew_limit_q;
  logic [PINS-1:0] input_threshold_sel_q;
  logic [PINS-1:0] pullup_enable_q;
  logic [PINS-1:0] rise_en_q;
  logic [PINS-1:0] fall_en_q;
  logic [11:0] bus_pad_ctrl_q;
  logic [3:0] single_ctrl_q;
  logic [PINS-1:0] pin_meta_q;
  logic [PINS-1:0] pin_sync_q;
  logic [PINS-1:0] pin_prev_q;
  logic [GPP_BUS_PADS-1:0] bus_meta_q;
  logic [GPP_BUS_PADS-1:0] bus_sync_q;
  logic single_meta_q;
  logic single_sync_q;
  logic single_prev_q;
  logic ack_q;
  logic [GPP_DAT_W-1:0] rdata_q;
  logic [PINS-1:0] pin_read;
  logic single_read;
  logic single_avail;
  logic req;
  logic wr;
  logic [GPP_DAT_W-1:0] rdata_d;
  logic [PINS-1:0] bus_mode;
  logic [PINS-1:0] bus_level;

  // register word select
  function automatic logic hit(input logic [GPP_ADR_W-1:0] adr, input logic [7:0] off);
    hit = (adr[GPP_ADR_W-1:2] == off[GPP_ADR_W-1:2]);
  endfunction

  // two-stage synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      bus_meta_q <= '0;
      bus_sync_q <= '0;
      single_meta_q <= 1'b0;
      single_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= pad_in_i;
      pin_sync_q <= pin_meta_q;
      bus_meta_q <= bus_st_in_i;
      bus_sync_q <= bus_meta_q;
      single_meta_q <= single_input_pin_i;
      single_sync_q <= single_meta_q;
    end
  end

  // digital view of the pins
  assign pin_read = pin_sync_q & ~analog_select_q;
  assign single_avail = ~master_clear_enable_i & ~low_volt_prog_enable_i;
  assign single_read = master_clear_enable_i | single_sync_q;

  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = req & wb_we_i;

  // read mux
  always_comb begin
    rdata_d = '0;
    if (hit(wb_adr_i, GPP_OFF_PIN_LEVEL)) begin
      rdata_d[PINS-1:0] = pin_read;
    end else if (hit(wb_adr_i, GPP_OFF_LATCH)) begin
      rdata_d[PINS-1:0] = output_hold_latch_q;
    end else if (hit(wb_adr_i, GPP_OFF_DIR)) begin
      rdata_d[PINS-1:0] = direction_ctrl_q;
    end else if (hit(wb_adr_i, GPP_OFF_ANALOG)) begin
      rdata_d[PINS-1:0] = analog_select_q;
    end else if (hit(wb_adr_i, GPP_OFF_DRAIN)) begin
      rdata_d[PINS-1:0] = drain_select_q;
    end else if (hit(wb_adr_i, GPP_OFF_SLEW)) begin
      rdata_d[PINS-1:0] = slew_limit_q;
    end else if (hit(wb_adr_i, GPP_OFF_THRESH)) begin
      rdata_d[PINS-1:0] = input_threshold_sel_q;
    end else if (hit(wb_adr_i, GPP_OFF_PULLUP)) begin
      rdata_d[PINS-1:0] = pullup_enable_q;
    end else if (hit(wb_adr_i, GPP_OFF_RISE_EN)) begin
      rdata_d[PINS-1:0] = rise_en_q;
    end else if (hit(wb_adr_i, GPP_OFF_FALL_EN)) begin
      rdata_d[PINS-1:0] = fall_en_q;
    end else if (hit(wb_adr_i, GPP_OFF_BUS_PAD)) begin
      rdata_d[11:0] = bus_pad_ctrl_q;
    end else if (hit(wb_adr_i, GPP_OFF_SINGLE)) begin
      rdata_d[3:0] = single_ctrl_q;
      rdata_d[GPP_SG_LEVEL] = single_read;
    end
  end

  // bus handshake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= req;
      rdata_q <= req ? rdata_d : '0;
    end
  end

  // bus outputs straight from their flops
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // output latch, shared by both write paths
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      output_hold_latch_q <= GPP_RST_LATCH;
    end else if (wr && hit(wb_adr_i, GPP_OFF_PIN_LEVEL)) begin
      output_hold_latch_q <= wb_sel_i[0] ? wb_dat_i[PINS-1:0] : pin_read;
    end else if (wr && hit(wb_adr_i, GPP_OFF_LATCH) && wb_sel_i[0]) begin
      output_hold_latch_q <= wb_dat_i[PINS-1:0];
    end
  end

  // direction bits, set means input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      direction_ctrl_q <= GPP_RST_DIR;
    end else if (wr && wb_sel_i[0] && hit(wb_adr_i, GPP_OFF_DIR)) begin
      direction_ctrl_q <= wb_dat_i[PINS-1:0];
    end
  end

  // analog select bits, set means digital input buffer off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog_select_q <= GPP_RST_ANALOG;
    end else if (wr && wb_sel_i[0] && hit(wb_adr_i, GPP_OFF_ANALOG)) begin
      analog_select_q <= wb_dat_i[PINS-1:0];
    end
  end

  // drain select bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drain_select_q <= GPP_RST_DRAIN;
    end else if (wr && wb_sel_i[0] && hit(wb_adr_i, GPP_OFF_DRAIN)) begin
      drain_select_q <= wb_dat_i[PINS-1:0];
    end
  end

  // slew limit bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slew_limit_q <= GPP_RST_SLEW;
    end else if (wr && wb_sel_i[0] && hit(wb_adr_i, GPP_OFF_SLEW)) begin
      slew_limit_q <= wb_dat_i[PINS-1:0];
    end
  end

  // input threshold bits, set means schmitt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      input_threshold_sel_q <= GPP_RST_THRESH;
    end else if (wr && wb_sel_i[0] && hit(wb_adr_i, GPP_OFF_THRESH)) begin
      input_threshold_sel_q <= wb_dat_i[PINS-1:0];
    end
  end

  // weak pull-up enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pullup_enable_q <= GPP_RST_PULLUP;
    end else if (wr && wb_sel_i[0] && hit(wb_adr_i, GPP_OFF_PULLUP)) begin
      pullup_enable_q <= wb_dat_i[PINS-1:0];
    end
  end

  // rising edge enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rise_en_q <= GPP_RST_EDGE_EN;
    end else if (wr && wb_sel_i[0] && hit(wb_adr_i, GPP_OFF_RISE_EN)) begin
      rise_en_q <= wb_dat_i[PINS-1:0];
    end
  end

  // falling edge enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fall_en_q <= GPP_RST_EDGE_EN;
    end else if (wr && wb_sel_i[0] && hit(wb_adr_i, GPP_OFF_FALL_EN)) begin
      fall_en_q <= wb_dat_i[PINS-1:0];
    end
  end

  // bus pad and single pin control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_pad_ctrl_q <= GPP_RST_BUS_PAD;
      single_ctrl_q <= GPP_RST_SINGLE;
    end else begin
      if (wr && hit(wb_adr_i, GPP_OFF_BUS_PAD)) begin
        if (wb_sel_i[0]) begin
          bus_pad_ctrl_q[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          bus_pad_ctrl_q[11:8] <= wb_dat_i[11:8];
        end
      end
      if (wr && hit(wb_adr_i, GPP_OFF_SINGLE) && wb_sel_i[0]) begin
        single_ctrl_q <= {wb_dat_i[GPP_SG_FALL:GPP_SG_PULLUP], 1'b0};
      end
    end
  end

  // driven value, never high where drain select is set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_out_o <= '0;
    end else begin
      pad_out_o <= output_hold_latch_q & ~drain_select_q;
    end
  end

  // driver enable, off for inputs and for released drain pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_oe_o <= '0;
    end else begin
      pad_oe_o <= ~direction_ctrl_q & ~(drain_select_q & output_hold_latch_q);
    end
  end

  // pad slew limit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_slew_limit_o <= GPP_RST_SLEW;
    end else begin
      pad_slew_limit_o <= slew_limit_q;
    end
  end

  // ttl threshold where the schmitt bit is clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_ttl_sel_o <= '0;
    end else begin
      pad_ttl_sel_o <= ~input_threshold_sel_q;
    end
  end

  // pad weak pull-ups
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_pullup_o <= '0;
    end else begin
      pad_pullup_o <= pullup_enable_q;
    end
  end

  // digital input buffer, off for analog pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_in_buf_en_o <= '0;
    end else begin
      pad_in_buf_en_o <= ~analog_select_q;
    end
  end

  // bus receiver routing onto the designated pins
  always_comb begin
    bus_mode = '0;
    bus_level = '0;
    for (int k = 0; k < GPP_BUS_PADS; k++) begin
      bus_mode[BUS_PIN[k]] = bus_pad_ctrl_q[k*GPP_BP_FIELD_W+GPP_BP_THRESH];
      bus_level[BUS_PIN[k]] = bus_sync_q[k];
    end
  end

  // peripheral inputs, gated by analog select like port reads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      periph_in_o <= '0;
    end else begin
      periph_in_o <= ((bus_level & bus_mode) | (pin_read & ~bus_mode))
                     & ~analog_select_q;
    end
  end

  // bus pad options
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_slew_o <= '0;
      bus_pullup_o <= '0;
      bus_thresh_o <= '0;
    end else begin
      for (int k = 0; k < GPP_BUS_PADS; k++) begin
        bus_slew_o[k] <= bus_pad_ctrl_q[k*GPP_BP_FIELD_W+GPP_BP_SLEW];
        bus_pullup_o[k] <= bus_pad_ctrl_q[k*GPP_BP_FIELD_W+GPP_BP_PULLUP];
        bus_thresh_o[k] <= bus_pad_ctrl_q[k*GPP_BP_FIELD_W+GPP_BP_THRESH];
      end
    end
  end

  // edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_prev_q <= '0;
      single_prev_q <= 1'b0;
      edge_change_irq_o <= '0;
      single_edge_irq_o <= 1'b0;
      single_pin_pullup_o <= 1'b0;
    end else begin
      pin_prev_q <= pin_read;
      single_prev_q <= single_sync_q;
      edge_change_irq_o <= (pin_read & ~pin_prev_q & rise_en_q)
                         | (~pin_read & pin_prev_q & fall_en_q);
      single_edge_irq_o <= single_avail & ((single_sync_q & ~single_prev_q
                           & single_ctrl_q[GPP_SG_RISE]) | (~single_sync_q & single_prev_q
                           & single_ctrl_q[GPP_SG_FALL]));
      single_pin_pullup_o <= single_ctrl_q[GPP_SG_PULLUP] | master_clear_enable_i
                           | low_volt_prog_enable_i;
    end
  end
endmodule // gpp_port

/* File: verification/gpp_port_props.sv */
// checker on the port pins of gpp_port
// assumes gpp_port with eight pins, bound below
module gpp_port_props
  import gpp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [GPP_DAT_W-1:0] wb_dat_o,
  input wire logic [7:0] pad_oe_o,
  input wire logic [7:0] pad_slew_limit_o,
  input wire logic [7:0] pad_in_buf_en_o,
  input wire logic [7:0] periph_in_o,
  input wire logic master_clear_enable_i,
  input wire logic low_volt_prog_enable_i,
  input wire logic single_pin_pullup_o,
  input wire logic single_edge_irq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_read_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_reset_pad_state: assert property ($past(rst_i) |->
    pad_oe_o == 8'h00 && pad_slew_limit_o == 8'hff && pad_in_buf_en_o == 8'h00)
    else $error("pads not in reset state");
  a_single_pull_forced: assert property ((master_clear_enable_i || low_volt_prog_enable_i)
    |=> single_pin_pullup_o)
    else $error("single pin pull-up not forced");
  a_single_edge_off: assert property ((master_clear_enable_i || low_volt_prog_enable_i) &&
    $past(master_clear_enable_i || low_volt_prog_enable_i) |-> !single_edge_irq_o)
    else $error("single pin edge while unavailable");
  a_analog_reads_zero: assert property ((periph_in_o & ~pad_in_buf_en_o) == 8'h00)
    else $error("analog pin seen high");
  cover property (wb_ack_o);
  cover property (single_pin_pullup_o && !master_clear_enable_i);
  cover property (single_edge_irq_o);
endmodule // gpp_port_props

bind gpp_port gpp_port_props u_props (.*);

/* File: verification/gpp_board_model.sv */
// board model: resolves each port pin wire
// assumes bench supplies external drive values and enables
module gpp_board_model (
  input wire logic clk_i,
  input wire logic [7:0] pad_out_i,
  input wire logic [7:0] pad_oe_i,
  input wire logic [7:0] pullup_i,
  input wire logic [7:0] ext_val_i,
  input wire logic [7:0] ext_en_i,
  output logic [7:0] pad_in_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] last_q;
  always_ff @(posedge clk_i) begin
    last_q <= pad_in_o;
  end
  // driver wins, then board, then pull-up, else floating
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe_i[i]) pad_in_o[i] = pad_out_i[i];
      else if (ext_en_i[i]) pad_in_o[i] = ext_val_i[i];
      else if (pullup_i[i]) pad_in_o[i] = 1'b1;
      else pad_in_o[i] = ~last_q[i];
    end
  end
endmodule // gpp_board_model

/* File: verification/gpp_port_tb.sv */
// testbench for gpp_port over classic wishbone
// assumes board model on the pins, one 200 MHz clock
module gpp_port_tb;
  import gpp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, seen;
  logic [7:0] wb_adr_i, pad_in_i, pad_out_o, pad_oe_o, pad_slew_limit_o, pad_ttl_sel_o;
  logic [7:0] pad_pullup_o, pad_in_buf_en_o, periph_in_o, edge_change_irq_o, ext, ext_en;
  logic [3:0] wb_sel_i, bus_st_in_i, bus_slew_o, bus_pullup_o, bus_thresh_o;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic single_input_pin_i, master_clear_enable_i, low_volt_prog_enable_i;
  logic single_pin_pullup_o, single_edge_irq_o;
  logic [7:0] rv [13] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int error_cnt = 0;
  int checks = 0;
  gpp_port uut (.*);
  gpp_board_model u_board (.clk_i(clk_i), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
    .pullup_i(pad_pullup_o), .ext_val_i(ext), .ext_en_i(ext_en), .pad_in_o(pad_in_i));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
      input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(a, 1'b1, d, 4'h1);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0, 4'hf);
    chk(rd, e);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge clk_i);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    {rst_i, ext, ext_en} = {1'b1, 8'ha5, 8'hff};
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {bus_st_in_i, single_input_pin_i, master_clear_enable_i, low_volt_prog_enable_i} = '0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 13; i++) rdchk(8'(i * 4), rv[i]);
    chk(pad_oe_o, 8'h00);
    chk(pad_in_buf_en_o, 8'h00);
    $display("end reset values");
    wr(8'h0c, 32'h0);
    repeat (4) @(posedge clk_i);
    rdchk(8'h00, 32'ha5);
    chk(pad_in_buf_en_o, 8'hff);
    wr(8'h04, 32'h3c);
    wr(8'h08, 32'hf0);
    repeat (2) @(posedge clk_i);
    chk(pad_oe_o, 8'h0f);
    chk(pad_out_o & 8'h0f, 8'h0c);
    rdchk(8'h04, 32'h3c);
    wb(8'h00, 1'b1, 32'h5a, 4'h1);
    repeat (4) @(posedge clk_i);
    rdchk(8'h04, 32'h5a);
    wb(8'h00, 1'b1, 32'h0, 4'h0);
    rdchk(8'h04, 32'haa);
    wr(8'h0c, 32'hff);
    repeat (2) @(posedge clk_i);
    chk(pad_oe_o, 8'h0f);
    rdchk(8'h00, 32'h0);
    $display("end direction and latch");
    wr(8'h04, 32'h05);
    wr(8'h10, 32'h0f);
    wr(8'h14, 32'h12);
    wr(8'h1c, 32'h34);
    wr(8'h18, 32'h0f);
    wb(8'h28, 1'b1, 32'h249, 4'h3);
    repeat (2) @(posedge clk_i);
    chk(pad_oe_o, 8'h0a);
    chk(pad_out_o & 8'h0f, 8'h00);
    chk(pad_slew_limit_o, 8'h12);
    chk(pad_pullup_o, 8'h34);
    chk(pad_ttl_sel_o, 8'hf0);
    chk({bus_slew_o, bus_pullup_o, bus_thresh_o}, 12'hf00);
    $display("end pad options");
    ext <= 8'h25;
    wr(8'h0c, 32'h0);
    wr(8'h20, 32'h80);
    repeat (4) @(posedge clk_i);
    ext <= 8'ha5;
    seen = 1'b0;
    repeat (8) @(posedge clk_i) seen |= edge_change_irq_o[7];
    chk(seen, 1'b1);
    wr(8'h24, 32'h80);
    ext <= 8'h25;
    seen = 1'b0;
    repeat (8) @(posedge clk_i) seen |= edge_change_irq_o[7];
    chk(seen, 1'b1);
    $display("end edge event");
    bus_st_in_i <= 4'h1;
    repeat (3) @(posedge clk_i);
    chk(periph_in_o[1], 1'b0);
    wb(8'h28, 1'b1, 32'h4, 4'h3);
    repeat (4) @(posedge clk_i);
    chk(periph_in_o[1], 1'b1);
    chk(bus_thresh_o, 4'h1);
    $display("end bus pad input");
    master_clear_enable_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(single_pin_pullup_o, 1'b1);
    rdchk(8'h2c, 32'h1);
    master_clear_enable_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(single_pin_pullup_o, 1'b0);
    low_volt_prog_enable_i <= 1'b1;
    wr(8'h2c, 32'h4);
    single_input_pin_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(single_pin_pullup_o, 1'b1);
    single_input_pin_i <= 1'b0;
    low_volt_prog_enable_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    single_input_pin_i <= 1'b1;
    seen = 1'b0;
    repeat (8) @(posedge clk_i) seen |= single_edge_irq_o;
    chk(seen, 1'b1);
    $display("end single pin");
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(8'h08, 32'hff);
    rdchk(8'h0c, 32'hff);
    chk(pad_oe_o, 8'h00);
    $display("end second reset");
    tally_and_finish();
  end
endmodule // gpp_port_tb
